// ### core/scbs_top.sv
// Strap sampling, radio and system clock selection, memory enable forming
//
// Notes on behaviour
// - Transmit strap low selects the internally divided 1 MHz transmit clock.
// - Transmit strap high selects the external transmit clock input.
// - A 1 MHz receive clock is recovered from the received data edges and driven out.
// - System strap low picks the internally divided clock, high the user clock.
// - The master clock input is the reference for all divided clocks.
// - The block is held in reset while the active-low hardware reset is low.
// - Bank width strap low gives 8-bit first bank accesses, high 16-bit.
// - Boot source strap: 01 flash, 10 select one, 11 select zero, 00 reserved.
// - Select zero output enable is the OR of select zero and read strobe, both low.
// - Select one output enable is the OR of select one and read strobe, both low.
// - After reset strobes, selects and memory output enables are high, system clock enable low, address low, data released.
`timescale 1ns/1ps
module scbs_top (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_hw_reset_low,
    input  wire logic                         i_tx_clock_source_strap,
    input  wire logic                         i_sys_clock_source_strap,
    input  wire logic                         i_ext_tx_clock_in,
    input  wire logic                         i_user_clock_in,
    input  wire logic                         i_rx_data,
    input  wire logic                         i_boot_bank_width_strap,
    input  wire logic [1:0]                   i_boot_source_strap,
    input  wire logic                         i_ram_space_select_n,
    input  wire logic                         i_io_space_select_n,
    input  wire logic                         i_read_strobe_n,
    input  wire logic                         i_write_strobe_n,
    input  wire logic                         i_low_byte_select_n,
    input  wire logic                         i_high_byte_select_n,
    input  wire logic [scbs_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [scbs_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                         i_data_drive,
    output logic                              o_radio_tx_clk,
    output logic                              o_recovered_rx_clock,
    output logic                              o_sys_clk_sel,
    output logic                              o_sys_clk_en,
    output logic                              o_bank_width_16,
    output scbs_pkg::scbs_boot_t              o_boot_source,
    output logic                              o_boot_reserved,
    output logic                              o_in_reset,
    output logic                              o_ram_space_select_n,
    output logic                              o_io_space_select_n,
    output logic                              o_read_strobe_n,
    output logic                              o_write_strobe_n,
    output logic                              o_low_byte_select_n,
    output logic                              o_high_byte_select_n,
    output logic                              o_cs0_output_enable_n,
    output logic                              o_cs1_output_enable_n,
    output logic [scbs_pkg::ADDR_W-1:0]       o_ext_address_bus,
    output logic [scbs_pkg::DATA_W-1:0]       o_ext_data_bus,
    output logic                              o_ext_data_bus_oe_n
);
    import scbs_pkg::*;

    scbs_sync_if sync ();

    logic rstn_s1_q;
    logic rstn_s2_q;
    logic rstn_s3_q;
    logic run_q;
    scbs_state_t state_q;
    scbs_state_t state_d;

    // Clock, data and strap pins pass the shared synchroniser; a strap moving in reset stays safe
    scbs_pin_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pins    ({i_boot_source_strap, i_boot_bank_width_strap,
                     i_rx_data, i_user_clock_in, i_ext_tx_clock_in,
                     i_sys_clock_source_strap, i_tx_clock_source_strap}),
        .sync      (sync)
    );

    // Hardware reset pin is asynchronous: three stages, counted once two and three agree
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rstn_s1_q <= 1'b0;
            rstn_s2_q <= 1'b0;
            rstn_s3_q <= 1'b0;
            run_q     <= 1'b0;
        end else begin
            rstn_s1_q <= i_hw_reset_low;
            rstn_s2_q <= rstn_s1_q;
            rstn_s3_q <= rstn_s2_q;
            if (rstn_s2_q == rstn_s3_q) begin
                run_q <= rstn_s3_q;
            end
        end
    end

    wire pin_reset = !run_q;

    // Reset while the straps are followed, one latch cycle, then run
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SCBS_ST_RESET: begin
                if (!pin_reset) begin
                    state_d = SCBS_ST_LATCH;
                end
            end
            SCBS_ST_LATCH: begin
                state_d = pin_reset ? SCBS_ST_RESET : SCBS_ST_RUN;
            end
            SCBS_ST_RUN: begin
                if (pin_reset) begin
                    state_d = SCBS_ST_RESET;
                end
            end
            default: begin
                state_d = SCBS_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= SCBS_ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    wire running = (state_q == SCBS_ST_RUN);

    // Straps are followed while reset is held so the last value before release sticks
    logic       width_q;
    scbs_boot_t boot_q;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            width_q <= WIDTH_8;
            boot_q  <= SCBS_BOOT_RSVD;
        end else if (state_q == SCBS_ST_RESET) begin
            width_q <= sync.width_strap;
            boot_q  <= scbs_boot_t'(sync.boot_strap);
        end
    end

    // Divided clocks from the master reference; the receive count restarts on receive data edges
    logic [DIV_W-1:0] tx_cnt_q;
    logic [DIV_W-1:0] rx_cnt_q;
    logic [DIV_W-1:0] sys_cnt_q;
    logic             tx_div_q;
    logic             rx_div_q;
    logic             rx_data_q;
    wire tx_wrap  = (tx_cnt_q == DIV_LAST);
    wire rx_wrap  = (rx_cnt_q == DIV_LAST);
    wire sys_wrap = (sys_cnt_q == SYS_LAST);
    wire rx_edge  = sync.rx_data ^ rx_data_q;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_cnt_q  <= '0;
            rx_cnt_q  <= '0;
            sys_cnt_q <= '0;
            tx_div_q  <= 1'b0;
            rx_div_q  <= 1'b0;
            rx_data_q <= 1'b0;
        end else if (!running) begin
            tx_cnt_q  <= '0;
            rx_cnt_q  <= '0;
            sys_cnt_q <= '0;
            tx_div_q  <= 1'b0;
            rx_div_q  <= 1'b0;
            rx_data_q <= sync.rx_data;
        end else begin
            tx_cnt_q  <= tx_wrap ? '0 : tx_cnt_q + 1'b1;
            sys_cnt_q <= sys_wrap ? '0 : sys_cnt_q + 1'b1;
            rx_data_q <= sync.rx_data;
            if (tx_wrap) begin
                tx_div_q <= !tx_div_q;
            end
            // Data edge realigns phase so the clock tracks the sender
            if (rx_edge) begin
                rx_cnt_q <= RX_ALIGN;
            end else begin
                rx_cnt_q <= rx_wrap ? '0 : rx_cnt_q + 1'b1;
            end
            if (rx_wrap && !rx_edge) begin
                rx_div_q <= !rx_div_q;
            end
        end
    end

    // Clock muxes; the strap is static by design so no glitch-free switch is built
    logic user_clk_q;
    wire tx_clk_sel  = sync.tx_src ? sync.ext_tx : tx_div_q;
    wire sys_clk_en  = sync.sys_src ? (sync.user_clk & !user_clk_q) : sys_wrap;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            user_clk_q <= 1'b0;
        end else begin
            user_clk_q <= sync.user_clk;
        end
    end

    // Memory enables: low only when select and read strobe are both low
    wire cs0_oe_n = i_ram_space_select_n | i_read_strobe_n;
    wire cs1_oe_n = i_io_space_select_n | i_read_strobe_n;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_radio_tx_clk        <= 1'b0;
            o_recovered_rx_clock  <= 1'b0;
            o_sys_clk_sel         <= 1'b0;
            o_sys_clk_en          <= 1'b0;
            o_bank_width_16       <= WIDTH_8;
            o_boot_source         <= SCBS_BOOT_RSVD;
            o_boot_reserved       <= 1'b1;
            o_in_reset            <= 1'b1;
            o_ram_space_select_n  <= 1'b1;
            o_io_space_select_n   <= 1'b1;
            o_read_strobe_n       <= 1'b1;
            o_write_strobe_n      <= 1'b1;
            o_low_byte_select_n   <= 1'b1;
            o_high_byte_select_n  <= 1'b1;
            o_cs0_output_enable_n <= 1'b1;
            o_cs1_output_enable_n <= 1'b1;
            o_ext_address_bus     <= ADDR_RST;
            o_ext_data_bus        <= DATA_RST;
            o_ext_data_bus_oe_n   <= 1'b1;
        end else if (!running) begin
            o_radio_tx_clk        <= 1'b0;
            o_recovered_rx_clock  <= 1'b0;
            o_sys_clk_sel         <= sync.sys_src;
            o_sys_clk_en          <= 1'b0;
            o_in_reset            <= 1'b1;
            o_ram_space_select_n  <= 1'b1;
            o_io_space_select_n   <= 1'b1;
            o_read_strobe_n       <= 1'b1;
            o_write_strobe_n      <= 1'b1;
            o_low_byte_select_n   <= 1'b1;
            o_high_byte_select_n  <= 1'b1;
            o_cs0_output_enable_n <= 1'b1;
            o_cs1_output_enable_n <= 1'b1;
            o_ext_address_bus     <= ADDR_RST;
            o_ext_data_bus        <= DATA_RST;
            o_ext_data_bus_oe_n   <= 1'b1;
        end else begin
            o_radio_tx_clk        <= tx_clk_sel;
            o_recovered_rx_clock  <= rx_div_q;
            o_sys_clk_sel         <= sync.sys_src;
            o_sys_clk_en          <= sys_clk_en;
            o_bank_width_16       <= width_q;
            o_boot_source         <= boot_q;
            o_boot_reserved       <= (boot_q == SCBS_BOOT_RSVD);
            o_in_reset            <= 1'b0;
            o_ram_space_select_n  <= i_ram_space_select_n;
            o_io_space_select_n   <= i_io_space_select_n;
            o_read_strobe_n       <= i_read_strobe_n;
            o_write_strobe_n      <= i_write_strobe_n;
            o_low_byte_select_n   <= i_low_byte_select_n;
            o_high_byte_select_n  <= width_q ? i_high_byte_select_n : 1'b1;
            o_cs0_output_enable_n <= cs0_oe_n;
            o_cs1_output_enable_n <= cs1_oe_n;
            o_ext_address_bus     <= i_addr;
            o_ext_data_bus        <= i_wdata;
            o_ext_data_bus_oe_n   <= !i_data_drive;
        end
    end
endmodule : scbs_top

// ### core/scbs_pkg.sv
// Constants shared by the strap, clock and boot select block
package scbs_pkg;
    localparam int unsigned SYS_CLK_HZ     = 250_000_000;
    localparam int unsigned RADIO_CLK_HZ   = 1_000_000;
    // Half period of the 1 MHz radio clock, in system cycles
    localparam int unsigned RADIO_HALF_CYC = SYS_CLK_HZ / (2 * RADIO_CLK_HZ);
    localparam int unsigned DIV_W          = 8;
    localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(RADIO_HALF_CYC - 1);
    // Internal system clock divide: enable tick spacing in system cycles
    localparam int unsigned SYS_DIV_HALF   = 4;
    localparam logic [DIV_W-1:0] SYS_LAST  = DIV_W'(SYS_DIV_HALF - 1);
    // Recovered clock: a data edge restarts phase at this count
    localparam logic [DIV_W-1:0] RX_ALIGN  = DIV_W'(RADIO_HALF_CYC / 2);
    localparam int unsigned ADDR_W         = 20;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned SYNC_N         = 3;
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic              WIDTH_8  = 1'b0;
    localparam logic              WIDTH_16 = 1'b1;

    typedef enum logic [1:0] {
        SCBS_BOOT_RSVD  = 2'b00,
        SCBS_BOOT_FLASH = 2'b01,
        SCBS_BOOT_CS1   = 2'b10,
        SCBS_BOOT_CS0   = 2'b11
    } scbs_boot_t;

    typedef enum logic [2:0] {
        SCBS_ST_RESET = 3'b001,
        SCBS_ST_LATCH = 3'b010,
        SCBS_ST_RUN   = 3'b100
    } scbs_state_t;
endpackage : scbs_pkg

// ### core/scbs_sync_if.sv
// Bundle of synchronised pin levels passed from the synchroniser to the top
`timescale 1ns/1ps
interface scbs_sync_if;
    logic tx_src;
    logic sys_src;
    logic ext_tx;
    logic user_clk;
    logic rx_data;
    logic width_strap;
    logic [1:0] boot_strap;
    modport src (output tx_src, sys_src, ext_tx, user_clk, rx_data, width_strap, boot_strap);
    modport dst (input  tx_src, sys_src, ext_tx, user_clk, rx_data, width_strap, boot_strap);
endinterface : scbs_sync_if

// ### core/scbs_pin_sync.sv
// Three-stage synchronisers for the asynchronous pin inputs
`timescale 1ns/1ps
module scbs_pin_sync (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_pins,
    scbs_sync_if.src        sync
);
    import scbs_pkg::*;

    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] agreed_q;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    s1_q[g]     <= 1'b0;
                    s2_q[g]     <= 1'b0;
                    s3_q[g]     <= 1'b0;
                    agreed_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= i_pins[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // A change counts only once stages two and three agree
                    if (s2_q[g] == s3_q[g]) begin
                        agreed_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    assign sync.tx_src      = agreed_q[0];
    assign sync.sys_src     = agreed_q[1];
    assign sync.ext_tx      = agreed_q[2];
    assign sync.user_clk    = agreed_q[3];
    assign sync.rx_data     = agreed_q[4];
    assign sync.width_strap = agreed_q[5];
    assign sync.boot_strap  = agreed_q[7:6];
endmodule : scbs_pin_sync

// ### sim/scbs_properties.sv
// Port-level assertions for the strap, clock and boot select top
`timescale 1ns/1ps
module scbs_properties (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst,
    input wire logic                  i_hw_reset_low,
    input wire logic                  i_ram_space_select_n,
    input wire logic                  i_io_space_select_n,
    input wire logic                  i_read_strobe_n,
    input wire logic                  o_sys_clk_sel,
    input wire logic                  o_sys_clk_en,
    input wire logic                  o_bank_width_16,
    input wire scbs_pkg::scbs_boot_t  o_boot_source,
    input wire logic                  o_boot_reserved,
    input wire logic                  o_in_reset,
    input wire logic                  o_read_strobe_n,
    input wire logic                  o_write_strobe_n,
    input wire logic                  o_high_byte_select_n,
    input wire logic                  o_cs0_output_enable_n,
    input wire logic                  o_cs1_output_enable_n,
    input wire logic [19:0]           o_ext_address_bus,
    input wire logic                  o_ext_data_bus_oe_n
);
    import scbs_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Three running cycles leave room for the registered output stage
    sequence s_run;
        !o_in_reset [*3];
    endsequence
    sequence s_held;
        !i_hw_reset_low [*7];
    endsequence
    property p_cs0_oe;
        s_run |-> o_cs0_output_enable_n == $past(i_ram_space_select_n | i_read_strobe_n);
    endproperty
    property p_cs1_oe;
        s_run |-> o_cs1_output_enable_n == $past(i_io_space_select_n | i_read_strobe_n);
    endproperty
    property p_byte8;
        (s_run ##0 !o_bank_width_16) |-> o_high_byte_select_n;
    endproperty
    property p_idle;
        o_in_reset [*2] |-> o_cs0_output_enable_n && o_cs1_output_enable_n && o_read_strobe_n
            && o_write_strobe_n && o_ext_data_bus_oe_n && o_ext_address_bus == ADDR_RST;
    endproperty
    property p_hw_rst;
        s_held |-> o_in_reset;
    endproperty
    property p_hold;
        s_run |-> $stable(o_bank_width_16) && $stable(o_boot_source);
    endproperty
    property p_rsvd;
        s_run |-> o_boot_reserved == (o_boot_source == SCBS_BOOT_RSVD);
    endproperty
    property p_sys_en;
        o_sys_clk_en && !o_in_reset |=>
            !o_sys_clk_en ##[1:8] (o_sys_clk_en || o_sys_clk_sel || o_in_reset);
    endproperty
    a_cs0_oe: assert property (p_cs0_oe) else $error("cs0 enable wrong");
    a_cs1_oe: assert property (p_cs1_oe) else $error("cs1 enable wrong");
    a_byte8: assert property (p_byte8) else $error("high byte active in 8-bit");
    a_idle: assert property (p_idle) else $error("memory pins not idle");
    a_hw_rst: assert property (p_hw_rst) else $error("not held in reset");
    a_hold: assert property (p_hold) else $error("strap value moved");
    a_rsvd: assert property (p_rsvd) else $error("reserved flag wrong");
    a_sys_en: assert property (p_sys_en) else $error("system tick spacing");
endmodule : scbs_properties

// ### sim/scbs_board.sv
// Board-side model: clock sources and received data feeding the block
`timescale 1ns/1ps
module scbs_board #(
    parameter int USER_HALF = 10
) (
    input  wire logic i_sys_clk,
    input  wire logic i_loopback,
    input  wire logic i_recovered_rx_clock,
    output logic      o_ext_tx_clock_in,
    output logic      o_user_clock_in,
    output logic      o_rx_data
);
    int unsigned tick_q = 0;
    always @(posedge i_sys_clk) begin
        #1 tick_q <= tick_q + 1;
    end
    // Unlooped input flips every fourth cycle: fast, yet slow enough for the synchroniser
    assign o_ext_tx_clock_in = i_loopback ? i_recovered_rx_clock : tick_q[2];
    assign o_user_clock_in = (tick_q % (2 * USER_HALF)) < USER_HALF;
    // Rare data edges keep the recovered half period measurable
    assign o_rx_data = tick_q[12];
endmodule : scbs_board

// ### sim/scbs_top_bench.sv
// Self-checking bench for the strap, clock and boot select block
`timescale 1ns/1ps
module scbs_top_bench;
    import scbs_pkg::*;
    localparam int USER_HALF = 10;
    logic i_sys_clk = 1'h0, i_rst = 1'h1, i_hw_reset_low = 1'h0, loopback = 1'h0;
    logic i_tx_clock_source_strap = 1'h0, i_sys_clock_source_strap = 1'h0;
    logic i_boot_bank_width_strap = 1'h0, i_data_drive = 1'h0;
    logic [1:0] i_boot_source_strap = 2'h0;
    logic i_ram_space_select_n = 1'h1, i_io_space_select_n = 1'h1, i_read_strobe_n = 1'h1;
    logic i_write_strobe_n = 1'h1, i_low_byte_select_n = 1'h1, i_high_byte_select_n = 1'h1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    wire logic i_ext_tx_clock_in, i_user_clock_in, i_rx_data;
    logic o_radio_tx_clk, o_recovered_rx_clock, o_sys_clk_sel, o_sys_clk_en, o_bank_width_16;
    scbs_boot_t o_boot_source;
    logic o_boot_reserved, o_in_reset, o_ram_space_select_n, o_io_space_select_n;
    logic o_read_strobe_n, o_write_strobe_n, o_low_byte_select_n, o_high_byte_select_n;
    logic o_cs0_output_enable_n, o_cs1_output_enable_n, o_ext_data_bus_oe_n;
    logic [ADDR_W-1:0] o_ext_address_bus;
    logic [DATA_W-1:0] o_ext_data_bus;
    int num_errors = 0, checks_done = 0;

    scbs_top scbs_top_i (.*);
    scbs_board #(.USER_HALF(USER_HALF)) scbs_board_i (.i_sys_clk(i_sys_clk),
        .i_loopback(loopback), .i_recovered_rx_clock(o_recovered_rx_clock),
        .o_ext_tx_clock_in(i_ext_tx_clock_in), .o_user_clock_in(i_user_clock_in),
        .o_rx_data(i_rx_data));

    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    function automatic logic pick(input int which);
        return which == 0 ? o_radio_tx_clk : which == 1 ? o_recovered_rx_clock : o_sys_clk_en;
    endfunction : pick
    // Counts toggles (or tick pulses) over n cycles and keeps the last spacing
    task automatic sample(input int which, input int n, output int cnt, output int gap);
        logic prev;
        logic cur;
        int since;
        cnt = 0;
        gap = 0;
        since = 0;
        prev = pick(which);
        repeat (n) begin
            cyc(1);
            cur = pick(which);
            since++;
            if (which == 2 ? cur === 1'h1 : cur !== prev) begin
                cnt++;
                gap = since;
                since = 0;
            end
            prev = cur;
        end
    endtask : sample
    task automatic check_idle();
        chk(o_in_reset, 1'h1);
        chk({o_ram_space_select_n, o_io_space_select_n, o_read_strobe_n, o_write_strobe_n,
            o_low_byte_select_n, o_high_byte_select_n, o_cs0_output_enable_n,
            o_cs1_output_enable_n, o_ext_data_bus_oe_n}, 9'h1ff);
        chk(o_ext_address_bus, ADDR_RST);
    endtask : check_idle
    task automatic t_straps();
        i_high_byte_select_n = 1'h0;
        for (int k = 7; k >= 0; k--) begin
            i_hw_reset_low = 1'h0;
            i_boot_bank_width_strap = k[2];
            i_boot_source_strap = k[1:0];
            cyc(8);
            check_idle();
            i_hw_reset_low = 1'h1;
            cyc(10);
            chk(o_in_reset, 1'h0);
            // Second pass runs with the straps inverted
            repeat (2) begin
                chk(o_bank_width_16, k[2]);
                chk(o_boot_source, k[1:0]);
                chk(o_boot_reserved, k[1:0] == 2'h0);
                chk(o_high_byte_select_n, !k[2]);
                i_boot_bank_width_strap = ~k[2];
                i_boot_source_strap = ~k[1:0];
                cyc(8);
            end
        end
        $display("t_straps done");
    endtask : t_straps
    task automatic t_mem();
        for (int i = 0; i < 8; i++) begin
            {i_ram_space_select_n, i_io_space_select_n, i_read_strobe_n} = i[2:0];
            {i_write_strobe_n, i_low_byte_select_n} = {i[1], i[2]};
            i_high_byte_select_n = i[0];
            i_addr = 20'h00001 << i;
            i_wdata = 16'h00a5 << i;
            i_data_drive = i[1];
            cyc(1);
            chk(o_cs0_output_enable_n, i[2] | i[0]);
            chk(o_cs1_output_enable_n, i[1] | i[0]);
            chk(o_high_byte_select_n, 1'h1);
            chk({o_ram_space_select_n, o_io_space_select_n, o_read_strobe_n, o_write_strobe_n,
                o_low_byte_select_n}, {i[2:0], i[1], i[2]});
            chk({o_ext_address_bus, o_ext_data_bus_oe_n}, {i_addr, ~i[1]});
            if (i[1]) chk(o_ext_data_bus, i_wdata);
        end
        {i_ram_space_select_n, i_io_space_select_n, i_read_strobe_n, i_data_drive} = 4'he;
        {i_write_strobe_n, i_low_byte_select_n} = 2'h3;
        $display("t_mem done");
    endtask : t_mem
    task automatic t_radio();
        int cnt;
        int gap;
        sample(0, 1000, cnt, gap);
        chk(gap, RADIO_HALF_CYC);
        sample(1, 1000, cnt, gap);
        chk(gap, RADIO_HALF_CYC);
        i_tx_clock_source_strap = 1'h1;
        cyc(10);
        sample(0, 200, cnt, gap);
        // The board's unlooped clock flips every fourth cycle
        chk(cnt, 200 / 4);
        loopback = 1'h1;
        cyc(10);
        sample(0, 1000, cnt, gap);
        chk(cnt, 1000 / RADIO_HALF_CYC);
        $display("t_radio done");
    endtask : t_radio
    task automatic t_sys();
        int cnt;
        int gap;
        sample(2, 200, cnt, gap);
        chk(cnt, 200 / SYS_DIV_HALF);
        chk(o_sys_clk_sel, 1'h0);
        i_sys_clock_source_strap = 1'h1;
        cyc(10);
        sample(2, 200, cnt, gap);
        chk(cnt, 200 / (2 * USER_HALF));
        chk(o_sys_clk_sel, 1'h1);
        $display("t_sys done");
    endtask : t_sys
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        cyc(2);
        check_idle();
        i_rst = 1'h0;
        t_straps();
        t_mem();
        t_radio();
        t_sys();
        i_rst = 1'h1;
        cyc(1);
        check_idle();
        end_sim();
    end
    // Whole run needs about 4000 cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        num_errors++;
        end_sim();
    end
endmodule : scbs_top_bench

bind scbs_top scbs_properties scbs_properties_i (.*);
